/* File: verification/crc_top_tb.sv */
// crc_top_tb.sv: self-checking bench for the comparator and reference control block.
// assumes: crc_top with a plain register port, read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"

module crc_top_tb;
  import crc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  crc_addr_type reg_addr_i = 3'h0;
  crc_byte_type reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic cmp_one_raw_i = 1'b0;
  logic cmp_two_raw_i = 1'b0;
  crc_byte_type reg_rdata_o;
  logic cmp_one_power_o, cmp_two_power_o, cmp_one_plus_ladder_o, cmp_two_plus_ladder_o;
  logic [1:0] cmp_one_minus_channel_o, cmp_two_minus_channel_o, cmp_irq_pending_o, cmp_irq_high_prio_o;
  logic cmp_one_pin_o, cmp_two_pin_o, cmp_one_pin_oe_o, cmp_two_pin_oe_o;
  logic reference_power_o, reference_ext_rails_o, reference_output_pin_connect_o, wake_o;
  logic [4:0] reference_level_code_o;
  int bad_count = 0;
  int samples_checked = 0;
  crc_byte_type exp_q[$];
  logic rd_pend_q = 1'b0;
  crc_byte_type v1, v2, v3;

  crc_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sleep_i(sleep_i),
    .cmp_one_raw_i(cmp_one_raw_i), .cmp_two_raw_i(cmp_two_raw_i), .cmp_one_power_o(cmp_one_power_o),
    .cmp_two_power_o(cmp_two_power_o), .cmp_one_plus_ladder_o(cmp_one_plus_ladder_o),
    .cmp_two_plus_ladder_o(cmp_two_plus_ladder_o), .cmp_one_minus_channel_o(cmp_one_minus_channel_o),
    .cmp_two_minus_channel_o(cmp_two_minus_channel_o), .cmp_one_pin_o(cmp_one_pin_o),
    .cmp_two_pin_o(cmp_two_pin_o), .cmp_one_pin_oe_o(cmp_one_pin_oe_o), .cmp_two_pin_oe_o(cmp_two_pin_oe_o),
    .reference_power_o(reference_power_o), .reference_ext_rails_o(reference_ext_rails_o),
    .reference_level_code_o(reference_level_code_o),
    .reference_output_pin_connect_o(reference_output_pin_connect_o), .wake_o(wake_o),
    .cmp_irq_pending_o(cmp_irq_pending_o), .cmp_irq_high_prio_o(cmp_irq_high_prio_o));

  // 200 MHz system clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe: sample mid-cycle, away from the edge
  always @(posedge sys_clk_i) rd_pend_q <= reg_rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_pend_q && exp_q.size() > 0) begin
      check(reg_rdata_o, exp_q.pop_front());
    end
  end

  // strobes drop after one cycle, so back-to-back calls leave a one-cycle gap
  task automatic wr(input crc_addr_type a, input crc_byte_type d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input crc_addr_type a, input crc_byte_type e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  // raw change, then enough edges for sync, result and flag to land
  task automatic drive_raw(input int k, input logic v);
    @(posedge sys_clk_i);
    if (k == 1) cmp_two_raw_i <= v;
    else cmp_one_raw_i <= v;
    repeat (8) @(posedge sys_clk_i);
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(99840));
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    // random control layouts, each field must reach its own output
    repeat (4) begin
      v1 = 8'($urandom);
      v2 = 8'($urandom);
      v3 = 8'($urandom);
      wr(`CRC_OFF_CMP1, v1);
      wr(`CRC_OFF_CMP2, v2);
      wr(`CRC_OFF_REF, v3);
      @(negedge sys_clk_i);
      check({cmp_one_power_o, cmp_one_pin_oe_o, 3'h0, cmp_one_plus_ladder_o, cmp_one_minus_channel_o},
            v1 & 8'hc7);
      check({cmp_two_power_o, cmp_two_pin_oe_o, 3'h0, cmp_two_plus_ladder_o, cmp_two_minus_channel_o},
            v2 & 8'hc7);
      rd(`CRC_OFF_CMP1, v1);
      rd(`CRC_OFF_CMP2, v2);
      rd(`CRC_OFF_REF, v3);
    end
    wr(`CRC_OFF_CMP1, 8'h00);
    wr(`CRC_OFF_CMP2, 8'h00);
    @(negedge sys_clk_i);
    check({reference_power_o, reference_output_pin_connect_o, reference_ext_rails_o, reference_level_code_o},
          v3);
    // module disable keeps only bits 3:0 and overrides comparator power
    wr(`CRC_OFF_CMP1, 8'h80);
    wr(`CRC_OFF_PMD, 8'hff);
    rd(`CRC_OFF_PMD, 8'h0f);
    @(negedge sys_clk_i);
    check({7'h00, cmp_one_power_o}, 8'h00);
    wr(`CRC_OFF_PMD, 8'h00);
    @(negedge sys_clk_i);
    check({7'h00, cmp_one_power_o}, 8'h01);
    wr(`CRC_OFF_STAT, 8'hff);
    rd(`CRC_OFF_STAT, 8'h00);
    // every edge code on both comparators, enables left clear
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        wr(k == 1 ? `CRC_OFF_CMP2 : `CRC_OFF_CMP1, 8'h80 | {3'h0, c[1:0], 3'h0});
        wr(`CRC_OFF_FLAGS, 8'h00);
        drive_raw(k, 1'b1);
        rd(`CRC_OFF_STAT, k == 1 ? 8'h80 : 8'h40);
        check({6'h00, cmp_two_pin_o, cmp_one_pin_o}, k == 1 ? 8'h02 : 8'h01);
        rd(`CRC_OFF_FLAGS, (c == 1 || c == 3) ? (k == 1 ? 8'h20 : 8'h10) : 8'h00);
        wr(`CRC_OFF_FLAGS, 8'h00);
        drive_raw(k, 1'b0);
        rd(`CRC_OFF_FLAGS, (c == 2 || c == 3) ? (k == 1 ? 8'h20 : 8'h10) : 8'h00);
      end
    end
    // inverted comparator two: raw low reads high, raw rise is a falling edge and sets no flag
    wr(`CRC_OFF_CMP1, 8'h00);
    wr(`CRC_OFF_CMP2, 8'ha8);
    repeat (8) @(posedge sys_clk_i);
    wr(`CRC_OFF_FLAGS, 8'h00);
    rd(`CRC_OFF_STAT, 8'h80);
    check({7'h00, cmp_two_pin_o}, 8'h01);
    drive_raw(1, 1'b1);
    rd(`CRC_OFF_FLAGS, 8'h00);
    // sleep: an enabled event wakes, controls survive
    wr(`CRC_OFF_ENAB, 8'h20);
    wr(`CRC_OFF_PRIO, 8'h30);
    rd(`CRC_OFF_PRIO, 8'h30);
    @(posedge sys_clk_i);
    sleep_i <= 1'b1;
    @(negedge sys_clk_i);
    check({7'h00, wake_o}, 8'h00);
    drive_raw(1, 1'b0);
    check({7'h00, wake_o}, 8'h01);
    check({4'h0, cmp_irq_pending_o, cmp_irq_high_prio_o}, 8'h0b);
    @(posedge sys_clk_i);
    sleep_i <= 1'b0;
    rd(`CRC_OFF_CMP2, 8'ha8);
    rd(`CRC_OFF_REF, v3);
    check({7'h00, wake_o}, 8'h00);
    wr(`CRC_OFF_FLAGS, 8'h10);
    rd(`CRC_OFF_FLAGS, 8'h10);
    // a zero write meeting a hardware event in the same cycle loses to it
    wr(`CRC_OFF_CMP2, 8'h98);
    wr(`CRC_OFF_FLAGS, 8'h00);
    rd(`CRC_OFF_FLAGS, 8'h20);
    // software powers down before sleep, so a raw change cannot wake the part
    wr(`CRC_OFF_CMP2, 8'h00);
    wr(`CRC_OFF_REF, v3 & 8'h7f);
    wr(`CRC_OFF_FLAGS, 8'h00);
    @(posedge sys_clk_i);
    sleep_i <= 1'b1;
    drive_raw(1, 1'b1);
    check({5'h00, cmp_two_power_o, reference_power_o, wake_o}, 8'h00);
    sleep_i <= 1'b0;
    // load controls and flags so the reset below has something to clear
    wr(`CRC_OFF_CMP2, 8'hff);
    wr(`CRC_OFF_REF, 8'hff);
    wr(`CRC_OFF_FLAGS, 8'h30);
    // reset in mid-run clears controls and flags
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({reference_power_o, reference_output_pin_connect_o, cmp_two_power_o, wake_o, 4'h0}, 8'h00);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`CRC_OFF_CMP2, 8'h00);
    rd(`CRC_OFF_REF, 8'h00);
    rd(`CRC_OFF_FLAGS, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: verilog/crc_cfg.svh */
// crc_cfg.svh: register offsets, field positions, reset values for the
// comparator and reference control block.
// assumes: included by its bare name from the package and design files.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

`define CRC_ADDR_W 3
`define CRC_OFF_CMP1 3'h0
`define CRC_OFF_CMP2 3'h1
`define CRC_OFF_REF 3'h2
`define CRC_OFF_STAT 3'h3
`define CRC_OFF_FLAGS 3'h4
`define CRC_OFF_ENAB 3'h5
`define CRC_OFF_PRIO 3'h6
`define CRC_OFF_PMD 3'h7

`define CRC_CTL_RESET 8'h00
`define CRC_REF_RESET 8'h00
`define CRC_REG_ZERO 8'h00

`define CRC_CTL_PWR 7
`define CRC_CTL_OE 6
`define CRC_CTL_INV 5
`define CRC_CTL_EV_HI 4
`define CRC_CTL_EV_LO 3
`define CRC_CTL_PSEL 2
`define CRC_CTL_CH_HI 1
`define CRC_CTL_CH_LO 0

`define CRC_STAT_TWO 7
`define CRC_STAT_ONE 6
`define CRC_FLG_TWO 5
`define CRC_FLG_ONE 4
`define CRC_CMP_MASK 8'h30
`define CRC_PMD_MASK 8'h0f
`define CRC_PMD_ONE 0
`define CRC_PMD_TWO 1

`define CRC_REF_EN 7
`define CRC_REF_OE 6
`define CRC_REF_SS 5
`define CRC_REF_LV_HI 4
`define CRC_REF_LV_LO 0

`endif

/* File: verilog/crc_cmp_event.sv */
// crc_cmp_event.sv: one comparator's digital output path: synchroniser,
// polarity, edge-selected event pulse.
// assumes: raw_i comes from the analog comparator, asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"

module crc_cmp_event (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  input wire logic power_on_i,
  input wire logic invert_i,
  input wire crc_pkg::crc_event_type edge_sel_i,
  output logic result_o,
  output logic event_o
);
  import crc_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic res_q;
  logic res_d;
  logic rise_w;
  logic fall_w;
  logic hit_w;

  // two flops before anything reads the analog level
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
    end
  end

  // polarity applied before status, pin and edge detector
  assign res_d = power_on_i & (sync2_q ^ invert_i);

  // result and its previous value; one step per edge so one transition
  // gives one event
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      res_q <= res_d;
      prev_q <= res_q;
    end
  end

  assign rise_w = res_q & ~prev_q;
  assign fall_w = ~res_q & prev_q;
  // edge select decode
  assign hit_w = (edge_sel_i == CRC_EV_RISE) ? rise_w :
                 (edge_sel_i == CRC_EV_FALL) ? fall_w :
                 (edge_sel_i == CRC_EV_ANY) ? (rise_w | fall_w) : 1'b0;
  assign event_o = hit_w;
  assign result_o = res_q;

  no_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (edge_sel_i == CRC_EV_NONE) |-> !event_o)
    else $error("event raised with edge select none");
  rise_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (edge_sel_i == CRC_EV_RISE && res_q && !prev_q) |-> event_o)
    else $error("rising edge missed");
  single_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (event_o && $stable(sync2_q) && $stable(power_on_i) && $stable(invert_i)) |=> !event_o)
    else $error("one transition gave two events");
endmodule

`default_nettype wire

/* File: verilog/crc_pkg.sv */
// crc_pkg.sv: types shared by the comparator/reference control block.
// assumes: crc_cfg.svh on the include path.
`include "crc_cfg.svh"

package crc_pkg;
  typedef logic [7:0] crc_byte_type;
  typedef logic [`CRC_ADDR_W-1:0] crc_addr_type;
  // event edge select codes
  typedef enum logic [1:0] {
    CRC_EV_NONE = 2'h0,
    CRC_EV_RISE = 2'h1,
    CRC_EV_FALL = 2'h2,
    CRC_EV_ANY = 2'h3
  } crc_event_type;
endpackage

/* File: verilog/crc_top.sv */
// crc_top.sv: register file and control for two comparators and the
// 32-tap reference ladder; analog parts sit outside as plain ports.
// assumes: single clock, plain register port with read data one cycle late.
`timescale 1ns/1ps
`default_nettype none
`include "crc_cfg.svh"

module crc_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire crc_pkg::crc_addr_type reg_addr_i,
  input wire crc_pkg::crc_byte_type reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output crc_pkg::crc_byte_type reg_rdata_o,
  input wire logic sleep_i,
  input wire logic cmp_one_raw_i,
  input wire logic cmp_two_raw_i,
  output logic cmp_one_power_o,
  output logic cmp_two_power_o,
  output logic cmp_one_plus_ladder_o,
  output logic cmp_two_plus_ladder_o,
  output logic [1:0] cmp_one_minus_channel_o,
  output logic [1:0] cmp_two_minus_channel_o,
  output logic cmp_one_pin_o,
  output logic cmp_two_pin_o,
  output logic cmp_one_pin_oe_o,
  output logic cmp_two_pin_oe_o,
  output logic reference_power_o,
  output logic reference_ext_rails_o,
  output logic [4:0] reference_level_code_o,
  output logic reference_output_pin_connect_o,
  output logic wake_o,
  output logic [1:0] cmp_irq_pending_o,
  output logic [1:0] cmp_irq_high_prio_o
);
  import crc_pkg::*;

  crc_byte_type ctl_one_q;
  crc_byte_type ctl_two_q;
  crc_byte_type ref_q;
  crc_byte_type flags_q;
  crc_byte_type flags_d;
  crc_byte_type enab_q;
  crc_byte_type prio_q;
  crc_byte_type pmd_q;
  crc_byte_type rdata_q;
  crc_byte_type rdata_d;
  crc_byte_type stat_w;
  logic res_one_w;
  logic res_two_w;
  logic ev_one_w;
  logic ev_two_w;
  logic wr_ctl_one_w;
  logic wr_ctl_two_w;
  logic wr_ref_w;
  logic wr_flags_w;
  logic wr_enab_w;
  logic wr_prio_w;
  logic wr_pmd_w;
  crc_byte_type ev_mask_w;
  logic pwr_one_w;
  logic pwr_two_w;

  // address decode shared by every write strobe
  function automatic logic hit(input crc_addr_type a, input crc_addr_type off);
    hit = (a == off);
  endfunction

  assign wr_ctl_one_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_CMP1);
  assign wr_ctl_two_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_CMP2);
  assign wr_ref_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_REF);
  assign wr_flags_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_FLAGS);
  assign wr_enab_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_ENAB);
  assign wr_prio_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_PRIO);
  assign wr_pmd_w = reg_wr_i & hit(reg_addr_i, `CRC_OFF_PMD);

  // control registers change only by reset or software write; sleep and
  // wake never touch them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_one_q <= `CRC_CTL_RESET;
      ctl_two_q <= `CRC_CTL_RESET;
      ref_q <= `CRC_REF_RESET;
    end else begin
      if (wr_ctl_one_w) begin
        ctl_one_q <= reg_wdata_i;
      end
      if (wr_ctl_two_w) begin
        ctl_two_q <= reg_wdata_i;
      end
      if (wr_ref_w) begin
        ref_q <= reg_wdata_i;
      end
    end
  end

  // enable, priority and module-disable registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enab_q <= `CRC_REG_ZERO;
      prio_q <= `CRC_REG_ZERO;
      pmd_q <= `CRC_REG_ZERO;
    end else begin
      if (wr_enab_w) begin
        enab_q <= reg_wdata_i & `CRC_CMP_MASK;
      end
      if (wr_prio_w) begin
        prio_q <= reg_wdata_i & `CRC_CMP_MASK;
      end
      if (wr_pmd_w) begin
        pmd_q <= reg_wdata_i & `CRC_PMD_MASK;
      end
    end
  end

  // a comparator runs if powered and not module-disabled; sleep is not
  // an input here, so it keeps running in sleep
  assign pwr_one_w = ctl_one_q[`CRC_CTL_PWR] & ~pmd_q[`CRC_PMD_ONE];
  assign pwr_two_w = ctl_two_q[`CRC_CTL_PWR] & ~pmd_q[`CRC_PMD_TWO];

  crc_cmp_event u_cmp_one (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i(cmp_one_raw_i),
    .power_on_i(pwr_one_w),
    .invert_i(ctl_one_q[`CRC_CTL_INV]),
    .edge_sel_i(crc_event_type'(ctl_one_q[`CRC_CTL_EV_HI:`CRC_CTL_EV_LO])),
    .result_o(res_one_w),
    .event_o(ev_one_w)
  );

  crc_cmp_event u_cmp_two (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i(cmp_two_raw_i),
    .power_on_i(pwr_two_w),
    .invert_i(ctl_two_q[`CRC_CTL_INV]),
    .edge_sel_i(crc_event_type'(ctl_two_q[`CRC_CTL_EV_HI:`CRC_CTL_EV_LO])),
    .result_o(res_two_w),
    .event_o(ev_two_w)
  );

  // events land on their flag positions
  assign ev_mask_w = {2'h0, ev_two_w, ev_one_w, 4'h0};

  // flags: write replaces the comparator bits (zero clears, one sets a
  // simulated event); a hardware event in the same cycle wins over the
  // clear; enables play no part here
  assign flags_d = (wr_flags_w ? (reg_wdata_i & `CRC_CMP_MASK) : flags_q) | ev_mask_w;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= `CRC_REG_ZERO;
    end else begin
      flags_q <= flags_d;
    end
  end

  // status: live results, low bits zero
  assign stat_w = {res_two_w, res_one_w, 6'h00};

  // read mux; unmapped offsets cannot occur with a full 3-bit decode
  always_comb begin
    rdata_d = `CRC_REG_ZERO;
    unique case (reg_addr_i)
      `CRC_OFF_CMP1: rdata_d = ctl_one_q;
      `CRC_OFF_CMP2: rdata_d = ctl_two_q;
      `CRC_OFF_REF: rdata_d = ref_q;
      `CRC_OFF_STAT: rdata_d = stat_w;
      `CRC_OFF_FLAGS: rdata_d = flags_q;
      `CRC_OFF_ENAB: rdata_d = enab_q;
      `CRC_OFF_PRIO: rdata_d = prio_q;
      `CRC_OFF_PMD: rdata_d = pmd_q;
    endcase
  end

  // read data held one cycle, zero when no read so stale data never leaks
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= `CRC_REG_ZERO;
    end else begin
      rdata_q <= reg_rd_i ? rdata_d : `CRC_REG_ZERO;
    end
  end
  assign reg_rdata_o = rdata_q;

  // comparator analog controls straight from the control bits, except power, which module disable also gates
  assign cmp_one_power_o = pwr_one_w;
  assign cmp_two_power_o = pwr_two_w;
  assign cmp_one_plus_ladder_o = ctl_one_q[`CRC_CTL_PSEL];
  assign cmp_two_plus_ladder_o = ctl_two_q[`CRC_CTL_PSEL];
  assign cmp_one_minus_channel_o = ctl_one_q[`CRC_CTL_CH_HI:`CRC_CTL_CH_LO];
  assign cmp_two_minus_channel_o = ctl_two_q[`CRC_CTL_CH_HI:`CRC_CTL_CH_LO];
  // pin gets the polarity-corrected result
  assign cmp_one_pin_o = res_one_w;
  assign cmp_two_pin_o = res_two_w;
  assign cmp_one_pin_oe_o = ctl_one_q[`CRC_CTL_OE];
  assign cmp_two_pin_oe_o = ctl_two_q[`CRC_CTL_OE];

  // reference depends only on its own register, never on comparator
  // bits
  assign reference_power_o = ref_q[`CRC_REF_EN];
  assign reference_ext_rails_o = ref_q[`CRC_REF_SS];
  assign reference_level_code_o = ref_q[`CRC_REF_LV_HI:`CRC_REF_LV_LO];
  assign reference_output_pin_connect_o = ref_q[`CRC_REF_OE];

  // interrupt request and wake: flag and enable only; global enables
  // live in the core, which is why wake ignores them
  assign cmp_irq_pending_o = {flags_q[`CRC_FLG_TWO] & enab_q[`CRC_FLG_TWO],
                              flags_q[`CRC_FLG_ONE] & enab_q[`CRC_FLG_ONE]};
  assign cmp_irq_high_prio_o = {prio_q[`CRC_FLG_TWO], prio_q[`CRC_FLG_ONE]};
  assign wake_o = sleep_i & (|cmp_irq_pending_o);

  // sequences for the flag behaviour
  sequence ev_one_s;
    ev_one_w && !wr_flags_w;
  endsequence

  flag_sets_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ev_one_s |=> flags_q[`CRC_FLG_ONE])
    else $error("event did not set flag one");
  flag_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (flags_q[`CRC_FLG_TWO] && !wr_flags_w) |=> flags_q[`CRC_FLG_TWO])
    else $error("flag two dropped without a write");
  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_flags_w && ev_two_w) |=> flags_q[`CRC_FLG_TWO])
    else $error("clear beat a simultaneous event");
  wake_event_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sleep_i && ((flags_q & enab_q & `CRC_CMP_MASK) != `CRC_REG_ZERO)) |-> wake_o)
    else $error("no wake on enabled flag in sleep");
  ctl_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!wr_ctl_one_w) |=> (ctl_one_q == $past(ctl_one_q)))
    else $error("comparator control changed without a write");
  ref_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!wr_ref_w) |=> $stable(ref_q))
    else $error("reference control changed without a write");
  ref_pin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_ref_w |=> (reference_output_pin_connect_o == $past(reg_wdata_i[`CRC_REF_OE])))
    else $error("reference pin connect wrong");
  status_bits_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `CRC_OFF_STAT) |=>
      (reg_rdata_o == {$past(res_two_w), $past(res_one_w), 6'h00}))
    else $error("status read wrong");
  read_path_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `CRC_OFF_REF && !wr_ref_w) |=> (reg_rdata_o == ref_q))
    else $error("reference read wrong");

  // reset held over two edges, so the asynchronous clear has surely landed
  sequence held_reset_s;
    rst_i ##1 rst_i;
  endsequence

  // an enabled event of comparator two while the part sleeps
  sequence sleep_event_s;
    sleep_i && ev_two_w && enab_q[`CRC_FLG_TWO];
  endsequence

  // still asleep, enable not withdrawn in the meantime
  sequence still_asleep_s;
    sleep_i && enab_q[`CRC_FLG_TWO];
  endsequence

  // reset checks carry no disable iff, since reset is what they watch
  reset_ctl_a: assert property (@(posedge sys_clk_i)
    held_reset_s |-> (ctl_one_q == `CRC_CTL_RESET && ctl_two_q == `CRC_CTL_RESET))
    else $error("comparator control not cleared by reset");
  reset_off_a: assert property (@(posedge sys_clk_i)
    held_reset_s |-> (!cmp_one_power_o && !cmp_two_power_o && !cmp_one_pin_oe_o && !cmp_two_pin_oe_o))
    else $error("comparator left on during reset");
  reset_ref_a: assert property (@(posedge sys_clk_i)
    held_reset_s |-> (!reference_power_o && !reference_output_pin_connect_o))
    else $error("reference left on during reset");

  // reference fields follow a write one edge later and nothing else
  ref_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_ref_w |=> (reference_level_code_o == $past(reg_wdata_i[`CRC_REF_LV_HI:`CRC_REF_LV_LO])))
    else $error("reference level code not taken");
  ref_rails_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_ref_w |=> (reference_ext_rails_o == $past(reg_wdata_i[`CRC_REF_SS])))
    else $error("reference source select not taken");
  ref_alone_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_ctl_one_w || wr_ctl_two_w) |=> $stable({reference_power_o, reference_output_pin_connect_o,
      reference_ext_rails_o, reference_level_code_o}))
    else $error("reference moved on a comparator write");

  // comparator analog controls, module disable, interrupt priority and enable
  plus_sel_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_ctl_two_w |=> (cmp_two_plus_ladder_o == $past(reg_wdata_i[`CRC_CTL_PSEL])))
    else $error("plus input select not taken");
  pmd_one_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pmd_q[`CRC_PMD_ONE] |-> !cmp_one_power_o)
    else $error("disabled comparator one still powered");
  pmd_two_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pmd_q[`CRC_PMD_TWO] |-> !cmp_two_power_o)
    else $error("disabled comparator two still powered");
  prio_bits_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_prio_w |=> (cmp_irq_high_prio_o == $past({reg_wdata_i[`CRC_FLG_TWO], reg_wdata_i[`CRC_FLG_ONE]})))
    else $error("priority bits not taken");
  enab_bits_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_enab_w |=> (enab_q[`CRC_FLG_TWO] == $past(reg_wdata_i[`CRC_FLG_TWO])))
    else $error("enable bit not taken");

  // the comparator keeps flagging in sleep, and only sleep lets wake out
  sleep_wake_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sleep_event_s ##1 still_asleep_s |-> wake_o)
    else $error("event in sleep did not wake");
  wake_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sleep_i |-> !wake_o)
    else $error("wake raised while awake");

  // software writes: zero clears unless an event meets it, one forces
  flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_flags_w && !reg_wdata_i[`CRC_FLG_TWO] && !ev_two_w) |=> !flags_q[`CRC_FLG_TWO])
    else $error("flag two not cleared by a zero write");
  flag_force_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_flags_w && reg_wdata_i[`CRC_FLG_ONE]) |=> flags_q[`CRC_FLG_ONE])
    else $error("written one did not set flag one");
endmodule

`default_nettype wire
